/* File: include/hwsc_pkg.sv */
package hwsc_pkg;

  // Register map, byte addresses on an 8-bit AXI4-Lite address
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_WDOG   = 8'h08;

  // Control register fields
  localparam int CTRL_CRYSTAL = 0;
  localparam int CTRL_BO_EN   = 1;
  localparam int CTRL_HALT    = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register fields
  localparam int STAT_STATE   = 0;
  localparam int STAT_CAUSE   = 4;
  localparam int STAT_PIN_IN  = 6;
  localparam int STAT_ACC_UND = 7;
  localparam int STAT_RAM_UND = 8;

  // Wake cause codes
  localparam logic [1:0] CAUSE_PIN   = 2'h0;
  localparam logic [1:0] CAUSE_MIWU  = 2'h1;
  localparam logic [1:0] CAUSE_RESET = 2'h2;
  localparam logic [1:0] CAUSE_BROWN = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: instruction cycle is oscillator divided by ten
  localparam int         CLK_PERIOD_NS = 25;
  localparam int         CYC_DIV         = 10;
  localparam logic [3:0] CYC_LAST        = 4'(CYC_DIV - 1);
  localparam int         START_DELAY_CYC = 256;
  localparam logic [7:0] WD_LOAD       = 8'hFF;
  localparam logic [7:0] WD_ZERO       = 8'h00;

  typedef enum logic [3:0] {
    st_run   = 4'b0001,
    st_halt  = 4'b0010,
    st_delay = 4'b0100,
    st_exit  = 4'b1000
  } hwsc_state_t;

endpackage : hwsc_pkg

/* File: design/hwsc_halt_ctrl.sv */
// What this block does
// - Halt bit write stops all internal clocks
// - Halt pin rising edge wakes, non-crystal only
// - Multi-input wakeup port ends halt
// - External reset low ends halt
// - Brown-out ends halt when enabled
// - Crystal wake: oscillator first, 256 cycle delay
// - Delay start loads prescaler and counter ones
// - Prescaler steps per instruction cycle, osc/10
// - Crystal delay: clocks released at watchdog timeout or reset
// - Reset-pin exit skips start-up delay
// - RC/external: no delay, watchdog still loaded with ones
// - Reset or brown-out exit restarts at zero
// - Pin or wakeup exit resumes after halt
// - Reset exit, crystal: accumulator, timer undefined
// - Brown-out exit: registers and RAM unknown
// - Pin or wakeup exit keeps other state
// - Halt pin readable as input when running
// - Brown-out monitoring stays active in halt
// - External reset beats brown-out, cancels delay
// - Halt entry loads prescaler and counter ones
`timescale 1ns/100ps
`default_nettype none
module hwsc_halt_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Wake sources
  input  wire logic        halt_restart_pin,
  input  wire logic [7:0]  wake_port,
  input  wire logic        reset_pin_n,
  input  wire logic        brownout,
  // Core side
  output logic             core_clk_en,
  output logic             osc_en,
  output logic             core_reset,
  output logic             core_resume,
  output logic             acc_timer_undef,
  output logic             ram_undef,
  output logic             halt_pin_in,
  output logic [7:0]       wd_prescaler,
  output logic [7:0]       wd_counter
);

  hwsc_pkg::hwsc_state_t state;
  hwsc_pkg::hwsc_state_t next_state;
  logic       crystal;
  logic       bo_en;
  logic       halt_req;
  logic [1:0] cause;
  logic [1:0] next_cause;
  logic [3:0] cyc_cnt;
  logic       cyc_tick;
  logic       wr_go;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic [2:0] pin_s;
  logic [1:0] rst_s;
  logic [1:0] bo_s;
  logic [7:0] wk_s1;
  logic [7:0] wk_s2;
  logic       wake_any;
  logic       timeout;

  ////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; stage two feeds the logic, plus a third pin stage for the edge detector
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s <= 3'h0;
      rst_s <= 2'h3;
      bo_s  <= 2'h0;
      wk_s1 <= 8'h00;
      wk_s2 <= 8'h00;
    end
    else if (ce)
    begin
      pin_s <= {pin_s[1:0], halt_restart_pin};
      rst_s <= {rst_s[0], reset_pin_n};
      bo_s  <= {bo_s[0], brownout};
      wk_s1 <= wake_port;
      wk_s2 <= wk_s1;
    end
  end

  // Any asserted line of the wake port counts as a wakeup
  genvar gi;
  logic [7:0] wk_or;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_wk
      if (gi == 0)
      begin : g_first
        assign wk_or[gi] = wk_s2[gi];
      end
      else
      begin : g_rest
        assign wk_or[gi] = wk_or[gi-1] | wk_s2[gi];
      end
    end
  endgenerate
  assign wake_any = wk_or[7];

  ////////////////////////////////////////////////////////////////////
  // Instruction cycle divider, oscillator over ten
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cyc_cnt <= 4'h0;
    else if (ce)
      cyc_cnt <= (cyc_cnt == hwsc_pkg::CYC_LAST) ? 4'h0 : 4'(cyc_cnt + 4'h1);
  end
  assign cyc_tick = (cyc_cnt == hwsc_pkg::CYC_LAST);

  // Prescaler wrap after 256 ticks from all ones is the timeout
  assign timeout = (state == hwsc_pkg::st_delay) && cyc_tick
                   && (wd_prescaler == hwsc_pkg::WD_ZERO);

  ////////////////////////////////////////////////////////////////////
  // Wake decision; reset pin outranks brown-out, then pin, then port
  always_comb
  begin
    next_state = state;
    next_cause = cause;
    case (state)
      hwsc_pkg::st_run:
      begin
        if (halt_req)
          next_state = hwsc_pkg::st_halt;
      end
      hwsc_pkg::st_halt:
      begin
        if (!rst_s[1])
        begin
          next_state = hwsc_pkg::st_exit;
          next_cause = hwsc_pkg::CAUSE_RESET;
        end
        else if (bo_en && bo_s[1])
        begin
          next_state = crystal ? hwsc_pkg::st_delay
                               : hwsc_pkg::st_exit;
          next_cause = hwsc_pkg::CAUSE_BROWN;
        end
        else if (!crystal && pin_s[1] && !pin_s[2])
        begin
          next_state = hwsc_pkg::st_exit;
          next_cause = hwsc_pkg::CAUSE_PIN;
        end
        else if (wake_any)
        begin
          next_state = crystal ? hwsc_pkg::st_delay
                               : hwsc_pkg::st_exit;
          next_cause = hwsc_pkg::CAUSE_MIWU;
        end
      end
      hwsc_pkg::st_delay:
      begin
        if (!rst_s[1])
        begin
          next_state = hwsc_pkg::st_exit;
          next_cause = hwsc_pkg::CAUSE_RESET;
        end
        else if (timeout)
          next_state = hwsc_pkg::st_exit;
      end
      hwsc_pkg::st_exit:
        next_state = hwsc_pkg::st_run;
      default:
        next_state = hwsc_pkg::st_run;
    endcase
  end

  // State and cause registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= hwsc_pkg::st_run;
      cause <= hwsc_pkg::CAUSE_PIN;
    end
    else if (ce)
    begin
      state <= next_state;
      cause <= next_cause;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Watchdog chain: loaded on entry and on wake, counted during delay
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wd_prescaler <= hwsc_pkg::WD_LOAD;
      wd_counter   <= hwsc_pkg::WD_LOAD;
    end
    else if (ce)
    begin
      if (state == hwsc_pkg::st_run && halt_req)
      begin
        wd_prescaler <= hwsc_pkg::WD_LOAD;
        wd_counter   <= hwsc_pkg::WD_LOAD;
      end
      else if (state == hwsc_pkg::st_halt && next_state != hwsc_pkg::st_halt)
      begin
        wd_prescaler <= hwsc_pkg::WD_LOAD;
        wd_counter   <= hwsc_pkg::WD_LOAD;
      end
      else if (state == hwsc_pkg::st_delay && cyc_tick)
      begin
        wd_prescaler <= 8'(wd_prescaler - 8'h01);
        if (wd_prescaler == hwsc_pkg::WD_ZERO)
          wd_counter <= 8'(wd_counter - 8'h01);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Core outputs; all registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_clk_en     <= 1'b1;
      osc_en          <= 1'b1;
      core_reset      <= 1'b0;
      core_resume     <= 1'b0;
      acc_timer_undef <= 1'b0;
      ram_undef       <= 1'b0;
      halt_pin_in     <= 1'b0;
    end
    else if (ce)
    begin
      // Core clocks only while running; delay keeps oscillator alone
      core_clk_en <= (next_state == hwsc_pkg::st_run);
      osc_en      <= (next_state != hwsc_pkg::st_halt);
      core_reset  <= (next_state == hwsc_pkg::st_exit)
                     && next_cause[1];
      core_resume <= (next_state == hwsc_pkg::st_exit)
                     && !next_cause[1];
      if (next_state == hwsc_pkg::st_exit)
      begin
        acc_timer_undef <= (next_cause == hwsc_pkg::CAUSE_BROWN)
                           || (next_cause == hwsc_pkg::CAUSE_RESET && crystal);
        ram_undef       <= (next_cause == hwsc_pkg::CAUSE_BROWN);
      end
      // Pin value live as an input only while running, frozen in halt, delay and exit
      if (state == hwsc_pkg::st_run)
        halt_pin_in <= pin_s[1];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel; address and data taken in either order
  assign wr_go = !awready && !wready && !bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= hwsc_pkg::RESP_OKAY;
      aw_q    <= 8'h00;
      w_q     <= 32'h0000_0000;
      ws_q    <= 4'h0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_q    <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_q    <= wdata;
        ws_q   <= wstrb;
        wready <= 1'b0;
      end
      if (wr_go)
      begin
        bvalid <= 1'b1;
        bresp  <= (aw_q == hwsc_pkg::ADDR_CTRL) ? hwsc_pkg::RESP_OKAY
                                                : hwsc_pkg::RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Control register; halt bit is a one-cycle request, not stored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      crystal  <= hwsc_pkg::CTRL_RESET[0];
      bo_en    <= hwsc_pkg::CTRL_RESET[1];
      halt_req <= 1'b0;
    end
    else if (ce)
    begin
      halt_req <= 1'b0;
      if (wr_go && aw_q == hwsc_pkg::ADDR_CTRL && ws_q[0])
      begin
        crystal  <= w_q[hwsc_pkg::CTRL_CRYSTAL];
        bo_en    <= w_q[hwsc_pkg::CTRL_BO_EN];
        halt_req <= w_q[hwsc_pkg::CTRL_HALT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel; answer one cycle after address taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= hwsc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= hwsc_pkg::RESP_OKAY;
        rdata   <= 32'h0000_0000;
        case (araddr)
          hwsc_pkg::ADDR_CTRL:
            rdata <= {30'h0, bo_en, crystal};
          hwsc_pkg::ADDR_STATUS:
            rdata <= {23'h0, ram_undef, acc_timer_undef, halt_pin_in,
                      cause, state};
          hwsc_pkg::ADDR_WDOG:
            rdata <= {16'h0, wd_counter, wd_prescaler};
          default:
            rresp <= hwsc_pkg::RESP_SLVERR;
        endcase
      end
      if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : hwsc_halt_ctrl
`default_nettype wire

/* File: sim/hwsc_partner.sv */
`timescale 1ns/100ps
`default_nettype none
// Wake sources and supply monitor; each request is held for eight cycles
module hwsc_partner (
  input  wire logic       aclk,
  input  wire logic       fire,
  input  wire logic [1:0] src,
  input  wire logic [7:0] pat,
  output wire logic       pin,
  output wire logic [7:0] port,
  output wire logic       rst_n,
  output wire logic       bo
);
  logic [3:0] hold = 4'h0;
  logic [1:0] cur  = 2'h0;
  // Long enough for the sync flops and the pin edge detector to see it
  always_ff @(posedge aclk)
  begin
    if (fire)
    begin
      hold <= 4'h8;
      cur  <= src;
    end
    else if (hold != 4'h0)
      hold <= hold - 4'h1;
  end
  // Idle levels: pin low, port quiet, reset high, supply good
  assign pin   = (hold != 4'h0) && (cur == hwsc_pkg::CAUSE_PIN);
  assign port  = ((hold != 4'h0) && (cur == hwsc_pkg::CAUSE_MIWU)) ? pat : 8'h00;
  assign rst_n = !((hold != 4'h0) && (cur == hwsc_pkg::CAUSE_RESET));
  assign bo    = (hold != 4'h0) && (cur == hwsc_pkg::CAUSE_BROWN);
endmodule : hwsc_partner
`default_nettype wire

/* File: sim/hwsc_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module hwsc_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       core_clk_en,
  input wire logic       osc_en,
  input wire logic       core_reset,
  input wire logic       core_resume,
  input wire logic       halt_pin_in,
  input wire logic [7:0] wd_prescaler,
  input wire logic [7:0] wd_counter
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  property p_dark; !osc_en |-> !core_clk_en; endproperty
  a_dark: assert property (p_dark) else $error("core clock on in halt");
  property p_hload; $fell(osc_en) |-> wd_prescaler == 8'hFF && wd_counter == 8'hFF; endproperty
  a_hload: assert property (p_hload) else $error("watchdog not loaded at halt");
  property p_dload; $rose(osc_en) && !core_clk_en |-> {wd_counter, wd_prescaler} == 16'hFFFF;
  endproperty
  a_dload: assert property (p_dload) else $error("watchdog not loaded at delay");
  // A prescaler step in the delay is followed by eight quiet cycles, or by the clock release
  property p_step; osc_en && !core_clk_en && $changed(wd_prescaler)
    |=> ($stable(wd_prescaler) || core_clk_en)[*8]; endproperty
  a_step: assert property (p_step) else $error("prescaler faster than tick");
  // Only a release that follows a running oscillator, not a reset exit, is a timeout
  property p_tout; $rose(core_clk_en) && $past(osc_en, 2) && !$past(core_reset)
    |-> wd_counter == 8'hFE; endproperty
  a_tout: assert property (p_tout) else $error("clocks released before timeout");
  property p_excl; core_reset |-> !core_resume; endproperty
  a_excl: assert property (p_excl) else $error("reset and resume together");
  property p_pulse; $rose(core_resume) |=> !core_resume; endproperty
  a_pulse: assert property (p_pulse) else $error("resume longer than a cycle");
  property p_pin; !osc_en |=> $stable(halt_pin_in); endproperty
  a_pin: assert property (p_pin) else $error("pin input moved in halt");
  c_rst: cover property (core_reset);
  c_res: cover property (core_resume);
  c_dly: cover property (osc_en && !core_clk_en);
endmodule : hwsc_chk
bind hwsc_halt_ctrl hwsc_chk u_chk (.aclk(aclk), .aresetn(aresetn), .core_clk_en(core_clk_en),
  .osc_en(osc_en), .core_reset(core_reset), .core_resume(core_resume),
  .halt_pin_in(halt_pin_in), .wd_prescaler(wd_prescaler), .wd_counter(wd_counter));
`default_nettype wire

/* File: sim/tb_halt_wakeup_startup_control.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_halt_wakeup_startup_control;
  logic        aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, got_rst;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, pat = 8'h01, port, wdp, wdc;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [1:0]  bresp, rresp, src = 2'h0;
  logic        awready, wready, bvalid, arready, rvalid, pin, rst_n, bo;
  logic        core_clk_en, osc_en, core_reset, core_resume, acc_u, ram_u, hpin;
  int          err_total = 0, samples_checked = 0, n;
  // 40 MHz oscillator
  always #12.5 aclk = ~aclk;
  hwsc_halt_ctrl dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .halt_restart_pin(pin), .wake_port(port), .reset_pin_n(rst_n),
    .brownout(bo), .core_clk_en(core_clk_en), .osc_en(osc_en), .core_reset(core_reset),
    .core_resume(core_resume), .acc_timer_undef(acc_u), .ram_undef(ram_u),
    .halt_pin_in(hpin), .wd_prescaler(wdp), .wd_counter(wdc));
  hwsc_partner u_far (.aclk(aclk), .fire(fire), .src(src), .pat(pat), .pin(pin),
    .port(port), .rst_n(rst_n), .bo(bo));
  ////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("unexpected %s exp %h seen %h", s, e, g);
      err_total++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk("bresp", 32'(e), 32'(bresp));
    // Idle edge so a following call never re-raises a handshake in this step
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd_v = rdata;
    chk("rresp", 32'(e), 32'(rresp));
    @(posedge aclk);
  endtask : rd
  // Random upper bits must not matter
  task automatic halt(input logic x, input logic b);
    wr(hwsc_pkg::ADDR_CTRL, ($urandom() & 32'hFFFFFFF8) | 32'h4 | {30'h0, b, x}, 2'h0);
    n = 0;
    while (osc_en !== 1'b0 && n < 10)
    begin
      @(posedge aclk);
      n++;
    end
    chk("osc_en", 32'h0, 32'(osc_en));
    chk("wdog", 32'hFFFF, {16'h0, wdc, wdp});
  endtask : halt
  task automatic wake(input logic [1:0] c);
    @(posedge aclk);
    src <= c;
    pat <= 8'h01 << $urandom_range(7);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
  endtask : wake
  task automatic pulse(input int lim);
    n = 0;
    while (core_reset !== 1'b1 && core_resume !== 1'b1 && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    got_rst = core_reset;
    chk("pulse in time", 32'h1, 32'(n < lim));
  endtask : pulse
  // Expected status word after an exit
  function automatic logic [31:0] stat(input logic [1:0] c, input logic x);
    stat = 32'h1 | (32'(c) << hwsc_pkg::STAT_CAUSE)
      | (32'((x && c == 2'h2) || c == 2'h3) << hwsc_pkg::STAT_ACC_UND)
      | (32'(c == 2'h3) << hwsc_pkg::STAT_RAM_UND);
  endfunction : stat
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  ////////////////////////////////////////
  // Watchdog against a hung wait
  initial
  begin
    #(25.0 * 20000);
    err_total++;
    results();
  end
  initial
  begin
    void'($urandom(32'hc53ee92f));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(hwsc_pkg::ADDR_STATUS, 2'h0);
    chk("status", 32'h1, rd_v);
    rd(hwsc_pkg::ADDR_WDOG, 2'h0);
    chk("wdog", 32'hFFFF, rd_v);
    rd(8'h0C, 2'h2);
    chk("unmapped", 32'h0, rd_v);
    wr(hwsc_pkg::ADDR_STATUS, 32'h0, 2'h2);
    $display("registers done");
    // Every source in RC mode with brown-out enabled
    for (int c = 0; c < 4; c++)
    begin
      halt(1'b0, 1'b1);
      wake(2'(c));
      pulse(20);
      chk("reset kind", 32'(c / 2), 32'(got_rst));
      chk("wdog", 32'hFFFF, {16'h0, wdc, wdp});
      // Pin still held high by the partner, now readable as an input
      repeat (2) @(posedge aclk);
      chk("pin input", 32'(c == 0), 32'(hpin));
      // Two instruction cycles of no-ops before software acts again
      repeat (2 * hwsc_pkg::CYC_DIV) @(posedge aclk);
      rd(hwsc_pkg::ADDR_STATUS, 2'h0);
      chk("status", stat(2'(c), 1'b0), rd_v);
    end
    $display("rc wake done");
    // Crystal start-up through the watchdog chain
    halt(1'b1, 1'b1);
    wake(2'h1);
    n = 0;
    while (osc_en !== 1'b1 && n < 20)
    begin
      @(posedge aclk);
      n++;
    end
    n = 0;
    got_rst = 1'b0;
    while (core_clk_en !== 1'b1 && n < 3000)
    begin
      @(posedge aclk);
      n++;
      // Resume pulse stands one cycle, before the clocks come back
      if (core_resume === 1'b1)
        got_rst = 1'b1;
    end
    // Free-running divider phase adds up to one instruction cycle
    chk("delay", 32'h1, 32'(n >= 2552 && n <= 2561));
    chk("counter", 32'hFE, 32'(wdc));
    chk("resume", 32'h1, 32'(got_rst));
    repeat (12) @(posedge aclk);
    $display("crystal delay done");
    // Ignored sources, then reset cancels a running delay
    halt(1'b1, 1'b0);
    wake(2'h0);
    repeat (30) @(posedge aclk);
    chk("osc_en", 32'h0, 32'(osc_en));
    wake(2'h3);
    repeat (30) @(posedge aclk);
    chk("osc_en", 32'h0, 32'(osc_en));
    wake(2'h1);
    repeat (100) @(posedge aclk);
    chk("in delay", 32'h2, {30'h0, osc_en, core_clk_en});
    wake(2'h2);
    pulse(20);
    chk("reset kind", 32'h1, 32'(got_rst));
    repeat (12) @(posedge aclk);
    rd(hwsc_pkg::ADDR_STATUS, 2'h0);
    chk("status", stat(2'h2, 1'b1), rd_v);
    // Reset pin in crystal mode skips the delay
    halt(1'b1, 1'b0);
    wake(2'h2);
    pulse(8);
    chk("reset kind", 32'h1, 32'(got_rst));
    $display("crystal reset done");
    results();
  end
endmodule : tb_halt_wakeup_startup_control
`default_nettype wire
